// ==== bench/tb_top.sv ====
// Self-checking testbench for the capture/compare status and time base block
`timescale 1ns/100ps
module tb_top
	import ccpst_pkg::*;
;
	logic clk;
	logic resetn;
	logic [ADDR_W-1:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic capture_input_pin;
	logic gate_source;
	logic shutdown_request;
	logic irq;
	logic shutdown_active;
	logic timer_running;
	logic secondary_match;
	int fail_count = 0;
	int checked = 0;
	logic [31:0] r;
	logic [31:0] a;
	logic [31:0] b;
	logic e;

	ccpst_top uut (
		.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .capture_input_pin(capture_input_pin),
		.gate_source(gate_source), .shutdown_request(shutdown_request), .irq(irq),
		.shutdown_active(shutdown_active), .timer_running(timer_running),
		.secondary_match(secondary_match)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task summarize;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk

	// One APB transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] ad, input logic [31:0] d);
		apb(ad, 1'b1, d);
	endtask : wr

	task rd(input logic [11:0] ad);
		apb(ad, 1'b0, 32'h0000_0000);
	endtask : rd

	task pulse_cap;
		@(posedge clk);
		capture_input_pin <= 1'b1;
		repeat (2) @(posedge clk);
		capture_input_pin <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse_cap

	task t_reset;
		rd(ADDR_PER_LOW); chk("per_low", 32'h0, r);
		rd(ADDR_PER_HIGH); chk("per_high", 32'h0, r);
		rd(ADDR_CMP_PRI); chk("cmp_pri", 32'h0, r);
		rd(ADDR_CMP_SEC); chk("cmp_sec", 32'h0, r);
		rd(ADDR_TB_HIGH); chk("tb_high", 32'h0, r);
		rd(ADDR_STATUS); chk("status", 32'h0080, r & 32'hFFF7);
		rd(12'hFFC); chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		@(negedge clk);
		chk("irq idle", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask : t_reset

	task t_regs;
		wr(ADDR_PER_LOW, 32'h0000_FFFF);
		wr(ADDR_PER_HIGH, 32'h0000_FFFF);
		rd(ADDR_PER_LOW); chk("per_low", 32'hFFFF, r);
		rd(ADDR_PER_HIGH); chk("per_high", 32'hFFFF, r);
		wr(ADDR_CMP_SEC, 32'h0000_A5C3);
		rd(ADDR_CMP_SEC); chk("cmp_sec", 32'hA5C3, r);
		wr(ADDR_TB_LOW, 32'h0000_0000);
		wr(ADDR_TB_HIGH, 32'h0000_1234);
		rd(ADDR_TB_HIGH); chk("tb_high", 32'h1234, r);
		rd(ADDR_TB_LOW); chk("tb_low small", 32'h1, {31'h0, r < 32'h20});
		$display("test registers done");
	endtask : t_regs

	task t_trigger;
		wr(ADDR_CONTROL, 32'h0000_0001);
		@(negedge clk); chk("running held", 32'h0, {31'h0, timer_running});
		rd(ADDR_STATUS); chk("trig held", 32'h0, {31'h0, r[7]});
		rd(ADDR_TB_LOW); chk("tb held zero", 32'h0, r);
		rd(ADDR_TB_LOW); chk("tb frozen", 32'h0, r);
		wr(ADDR_STATUS, 32'h0000_005F);
		@(negedge clk); chk("running set", 32'h1, {31'h0, timer_running});
		rd(ADDR_STATUS); chk("trig req bits", 32'h80, r & 32'hE0);
		wr(ADDR_STATUS, 32'h0000_003F);
		@(negedge clk); chk("running clr", 32'h0, {31'h0, timer_running});
		rd(ADDR_STATUS); chk("trig clr bits", 32'h0, r & 32'hE0);
		wr(ADDR_CONTROL, 32'h0000_0000);
		$display("test trigger done");
	endtask : t_trigger

	task t_compare;
		wr(ADDR_CMP_PRI, 32'h0000_0040);
		wr(ADDR_TB_LOW, 32'h0000_0000);
		wr(ADDR_STATUS, 32'h0000_0017);
		rd(ADDR_STATUS); chk("sce cleared", 32'h0, {31'h0, r[3]});
		rd(ADDR_IRQ_STATUS);
		repeat (80) @(posedge clk);
		rd(ADDR_STATUS); chk("sce set", 32'h1, {31'h0, r[3]});
		rd(ADDR_STATUS); chk("sce sticky", 32'h1, {31'h0, r[3]});
		@(negedge clk); chk("irq masked", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		@(negedge clk); chk("irq on", 32'h1, {31'h0, irq});
		rd(ADDR_IRQ_STATUS); chk("irq cmp", 32'h1, r & 32'h1);
		@(negedge clk); chk("irq cleared", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		// Low word lands sixteen counts short of the secondary compare value
		wr(ADDR_TB_LOW, 32'h0000_A5B3);
		a = 32'h0;
		repeat (40) begin
			@(negedge clk);
			a = a + {31'h0, secondary_match};
		end
		chk("sec match cycles", 32'h1, a);
		$display("test compare done");
	endtask : t_compare

	task t_capture;
		int i;
		pulse_cap();
		pulse_cap();
		rd(ADDR_STATUS); chk("bne", 32'h1, {31'h0, r[0]});
		rd(ADDR_CAPBUF_LOW); a[15:0] = r[15:0];
		rd(ADDR_CAPBUF_HIGH); a[31:16] = r[15:0];
		rd(ADDR_CAPBUF_LOW); b[15:0] = r[15:0];
		rd(ADDR_CAPBUF_HIGH); b[31:16] = r[15:0];
		chk("capture gap", 32'h5, b - a);
		rd(ADDR_STATUS); chk("empty", 32'h0, {31'h0, r[0]});
		chk("no ovf", 32'h0, {31'h0, r[1]});
		for (i = 0; i < 5; i++) begin
			pulse_cap();
		end
		rd(ADDR_STATUS); chk("ovf", 32'h3, r & 32'h3);
		for (i = 0; i < 4; i++) begin
			rd(ADDR_CAPBUF_LOW);
			rd(ADDR_CAPBUF_HIGH);
		end
		wr(ADDR_STATUS, 32'h0000_001D);
		rd(ADDR_STATUS); chk("ovf clr", 32'h0, r & 32'h3);
		$display("test capture done");
	endtask : t_capture

	task t_gating;
		gate_source <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("level dis", 32'h1, {31'h0, r[2]});
		pulse_cap();
		rd(ADDR_STATUS); chk("blocked", 32'h0, {31'h0, r[0]});
		gate_source <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("level en", 32'h0, {31'h0, r[2]});
		wr(ADDR_CONTROL, 32'h0000_0004);
		wr(ADDR_STATUS, 32'h0000_041F);
		rd(ADDR_STATUS); chk("arm reads 0", 32'h0, {31'h0, r[10]});
		gate_source <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("fall dis", 32'h1, {31'h0, r[2]});
		// Reserved mode: the gate leaves the disable alone, software clears it
		wr(ADDR_CONTROL, 32'h0000_0006);
		gate_source <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("rsvd holds", 32'h1, {31'h0, r[2]});
		wr(ADDR_STATUS, 32'h0000_001B);
		rd(ADDR_STATUS); chk("sw clr dis", 32'h0, {31'h0, r[2]});
		// Level mode with the gate low sets the disable again before one-shot rise
		gate_source <= 1'b0;
		wr(ADDR_CONTROL, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_0002);
		rd(ADDR_STATUS); chk("rise pre dis", 32'h1, {31'h0, r[2]});
		wr(ADDR_STATUS, 32'h0000_041F);
		gate_source <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("rise en", 32'h0, {31'h0, r[2]});
		pulse_cap();
		rd(ADDR_STATUS); chk("captures", 32'h1, {31'h0, r[0]});
		rd(ADDR_CAPBUF_LOW);
		rd(ADDR_CAPBUF_HIGH);
		wr(ADDR_CONTROL, 32'h0000_0000);
		$display("test gating done");
	endtask : t_gating

	task t_shutdown;
		shutdown_request <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS); chk("asd", 32'h1, {31'h0, r[4]});
		@(negedge clk); chk("sd pin", 32'h1, {31'h0, shutdown_active});
		wr(ADDR_STATUS, 32'h0000_000F);
		rd(ADDR_STATUS); chk("asd held", 32'h1, {31'h0, r[4]});
		shutdown_request <= 1'b0;
		repeat (2) @(posedge clk);
		wr(ADDR_STATUS, 32'h0000_000F);
		rd(ADDR_STATUS); chk("asd clr", 32'h0, {31'h0, r[4]});
		@(negedge clk); chk("sd pin off", 32'h0, {31'h0, shutdown_active});
		wr(ADDR_STATUS, 32'h0000_FB9F);
		rd(ADDR_STATUS); chk("unimpl", 32'h0, r & 32'hFF00);
		$display("test shutdown done");
	endtask : t_shutdown

	initial begin
		resetn = 1'b0;
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
		capture_input_pin = 1'b0;
		gate_source = 1'b1;
		shutdown_request = 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_regs();
		t_trigger();
		t_compare();
		t_capture();
		t_gating();
		t_shutdown();
		summarize();
	end

	// Bound well above the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule : tb_top

// ==== hw/ccpst_top.sv ====
// Capture/compare status, time base, period and compare registers on APB
// Notes on behaviour
// [R1] Gate arm write arms one-shot gating; reads zero
// [R2] Trigger status shows timer running or held
// [R3] Trigger set request starts triggered timer
// [R4] Trigger clear request cancels the trigger
// [R5] Shutdown status high while shutdown in progress
// [R6] Bits four..one clearable; requests write-one only
// [R7] Compare event bit sticky until software clears
// [R8] Capture disable blocks capture input events
// [R9] Overflow bit set on capture FIFO overflow
// [R10] Buffer status shows FIFO not empty
// [R11] Thirty-two bit time base, low/high words
// [R12] Thirty-two bit period, low/high words
// [R13] Primary sixteen-bit compare against time base
// [R14] Secondary sixteen-bit compare against time base
// [R15] One-shot gate edges set/clear disable; level direct
// [R16] Read buffer presents oldest captured value
// [R17] Compare flag raised when time base equals primary
// [R18] Unimplemented status bits read zero, ignore writes
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module ccpst_top
	import ccpst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Block inputs
	input wire logic capture_input_pin,
	input wire logic gate_source,
	input wire logic shutdown_request,
	// Block outputs
	output logic irq,
	output logic shutdown_active,
	output logic timer_running,
	output logic secondary_match
);
	logic setup;
	logic wr;
	logic rd;
	logic wr_status;
	logic rd_irq;
	logic pop;
	logic push;
	logic push_ok;
	logic full;
	logic running;
	logic sce_set;
	logic gate_rise;
	logic gate_fall;
	logic cap_edge;
	logic addr_ok;
	logic [15:0] status_word;
	logic [31:0] rd_word;
	logic [31:0] tb;
	logic [31:0] next_tb;
	logic [31:0] period;
	logic [15:0] cmp_pri;
	logic [15:0] cmp_sec;
	logic trig_en;
	ccpst_gsm_e gsm;
	ccpst_trig_e trig_state;
	logic asd;
	logic sce;
	logic cdis;
	logic cov;
	logic armed;
	logic gate_prev;
	logic cap_prev;
	logic [31:0] cap_mem [0:3];
	logic [CAP_PTR_W-1:0] wr_ptr;
	logic [CAP_PTR_W-1:0] rd_ptr;
	logic [2:0] count;
	logic [IRQ_W-1:0] irq_st;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_ev;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Zero wait state: every access completes in its first access cycle
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign wr_status = wr && (paddr == ADDR_STATUS);
	assign rd_irq = rd && (paddr == ADDR_IRQ_STATUS);

	// Configuration and data registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			period <= {RESET_WORD, RESET_WORD};
			cmp_pri <= RESET_WORD;
			cmp_sec <= RESET_WORD;
			trig_en <= 1'b0;
			gsm <= GSM_LEVEL;
			irq_mask <= '0;
		end else if (wr) begin
			case (paddr)
				ADDR_PER_LOW: period[15:0] <= pwdata[15:0]; // [R12]
				ADDR_PER_HIGH: period[31:16] <= pwdata[15:0]; // [R12]
				ADDR_CMP_PRI: cmp_pri <= pwdata[15:0]; // [R13]
				ADDR_CMP_SEC: cmp_sec <= pwdata[15:0]; // [R14]
				ADDR_CONTROL: begin
					trig_en <= pwdata[CTL_TRIGGERED_OPERATION_ENABLE];
					gsm <= ccpst_gsm_e'(pwdata[CTL_GSM_HI:CTL_GSM_LO]);
				end
				ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Trigger state; clear wins when both requests come together
	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_state <= TB_HELD;
		end else if (!trig_en) begin
			trig_state <= TB_HELD;
		end else if (wr_status && pwdata[BIT_TCLR]) begin
			trig_state <= TB_HELD; // [R4]
		end else if (wr_status && pwdata[BIT_TSET]) begin
			trig_state <= TB_RUN; // [R3]
		end
	end

	// Untriggered timer free-runs; triggered timer runs only once set
	assign running = ~trig_en | (trig_state == TB_RUN); // [R2]
	assign timer_running = running;

	// Time base: held at zero until triggered, wraps at period
	always_comb begin
		next_tb = tb;
		if (!running) begin
			next_tb = '0; // [R2]
		end else if (tb == period) begin
			next_tb = '0;
		end else begin
			next_tb = tb + 32'h1;
		end
		if (wr && paddr == ADDR_TB_LOW) begin
			next_tb[15:0] = pwdata[15:0]; // [R11]
		end
		if (wr && paddr == ADDR_TB_HIGH) begin
			next_tb[31:16] = pwdata[15:0]; // [R11]
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tb <= {RESET_WORD, RESET_WORD}; // [R11]
		end else begin
			tb <= next_tb;
		end
	end

	// Compare events
	assign sce_set = running && (tb[15:0] == cmp_pri); // [R13] [R17]

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sce <= 1'b0;
			secondary_match <= 1'b0;
		end else begin
			secondary_match <= running && (tb[15:0] == cmp_sec); // [R14]
			if (sce_set) begin
				sce <= 1'b1; // [R7]
			end else if (wr_status && !pwdata[BIT_SCE]) begin
				sce <= 1'b0; // [R6]
			end
		end
	end

	// Auto-shutdown status; a live request keeps it set against a clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			asd <= 1'b0;
		end else if (shutdown_request) begin
			asd <= 1'b1; // [R5]
		end else if (wr_status && !pwdata[BIT_ASD]) begin
			asd <= 1'b0; // [R6]
		end
	end
	assign shutdown_active = asd;

	// Gating source edges
	assign gate_rise = gate_source & ~gate_prev;
	assign gate_fall = ~gate_source & gate_prev;

	// Reset loads the live pin levels so no false edge follows reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gate_prev <= gate_source;
			cap_prev <= capture_input_pin;
		end else begin
			gate_prev <= gate_source;
			cap_prev <= capture_input_pin;
		end
	end

	// One-shot arm; spent by the gating edge it waits for
	always_ff @(posedge clk) begin
		if (!resetn) begin
			armed <= 1'b0;
		end else if (gsm != GSM_RISE && gsm != GSM_FALL) begin
			armed <= 1'b0;
		end else if (wr_status && pwdata[BIT_GATE_ARM]) begin
			armed <= 1'b1; // [R1]
		end else if ((gsm == GSM_FALL && gate_fall) || (gsm == GSM_RISE && gate_rise)) begin
			armed <= 1'b0;
		end
	end

	// Capture disable; hardware gating wins over a software clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cdis <= 1'b0;
		end else if (gsm == GSM_LEVEL) begin
			cdis <= ~gate_source; // [R15]
		end else if (armed && gsm == GSM_FALL && gate_fall) begin
			cdis <= 1'b1; // [R15]
		end else if (armed && gsm == GSM_RISE && gate_rise) begin
			cdis <= 1'b0; // [R15]
		end else if (wr_status && !pwdata[BIT_CDIS]) begin
			cdis <= 1'b0; // [R6]
		end
	end

	// Capture FIFO; reading the high buffer word pops the oldest entry
	assign cap_edge = capture_input_pin & ~cap_prev;
	assign push = cap_edge & ~cdis; // [R8]
	assign full = (count == CAP_FULL);
	assign pop = rd && (paddr == ADDR_CAPBUF_HIGH) && (count != '0);
	assign push_ok = push && (!full || pop);

	always_ff @(posedge clk) begin
		if (push_ok) begin
			cap_mem[wr_ptr] <= tb;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1; // [R16]
			end
			if (push_ok && !pop) begin
				count <= count + 3'h1;
			end else if (pop && !push_ok) begin
				count <= count - 3'h1;
			end
		end
	end

	// Overflow drops the new capture and keeps the older entries
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cov <= 1'b0;
		end else if (push && !push_ok) begin
			cov <= 1'b1; // [R9]
		end else if (wr_status && !pwdata[BIT_COV]) begin
			cov <= 1'b0; // [R6]
		end
	end

	// Sticky interrupt status, cleared by its read; a new event wins
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_COMPARE] = sce_set;
		irq_ev[IRQ_CAPTURE] = push_ok;
		irq_ev[IRQ_OVERFLOW] = push && !push_ok;
		irq_ev[IRQ_SHUTDOWN] = shutdown_request && !asd;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_st <= '0;
		end else if (rd_irq) begin
			irq_st <= irq_ev;
		end else begin
			irq_st <= irq_st | irq_ev;
		end
	end
	assign irq = |(irq_st & irq_mask);

	// Status word; requests, arm and unused bits read zero
	always_comb begin
		status_word = '0; // [R18]
		status_word[BIT_TRIG] = running; // [R2]
		status_word[BIT_ASD] = asd; // [R5]
		status_word[BIT_SCE] = sce;
		status_word[BIT_CDIS] = cdis;
		status_word[BIT_COV] = cov;
		status_word[BIT_CBNE] = (count != '0); // [R10]
	end

	// Read mux, sampled in the setup cycle so prdata comes from a flop
	always_comb begin
		rd_word = '0;
		addr_ok = 1'b1;
		case (paddr)
			ADDR_STATUS: rd_word[15:0] = status_word; // [R1] [R3] [R4]
			ADDR_TB_LOW: rd_word[15:0] = tb[15:0];
			ADDR_TB_HIGH: rd_word[15:0] = tb[31:16];
			ADDR_PER_LOW: rd_word[15:0] = period[15:0];
			ADDR_PER_HIGH: rd_word[15:0] = period[31:16];
			ADDR_CMP_PRI: rd_word[15:0] = cmp_pri;
			ADDR_CMP_SEC: rd_word[15:0] = cmp_sec;
			ADDR_CAPBUF_LOW: rd_word[15:0] = cap_mem[rd_ptr][15:0]; // [R16]
			ADDR_CAPBUF_HIGH: rd_word[15:0] = cap_mem[rd_ptr][31:16]; // [R16]
			ADDR_CONTROL: begin
				rd_word[CTL_TRIGGERED_OPERATION_ENABLE] = trig_en;
				rd_word[CTL_GSM_HI:CTL_GSM_LO] = gsm;
			end
			ADDR_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_st;
			ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0 : rd_word;
			pslverr <= ~addr_ok;
		end
	end

	// Checks
	status_zero_bits_a: assert property ( // [R18]
		setup && !pwrite && paddr == ADDR_STATUS |=> prdata[15:11] == 5'h0
			&& prdata[9:8] == 2'h0 && prdata[31:16] == 16'h0)
		else $error("reserved status bits not zero");
	request_bits_zero_a: assert property ( // [R1]
		setup && !pwrite && paddr == ADDR_STATUS |=> prdata[BIT_GATE_ARM] == 1'b0
			&& prdata[BIT_TSET] == 1'b0 && prdata[BIT_TCLR] == 1'b0)
		else $error("write-only status bits read non-zero");
	trig_set_run_a: assert property ( // [R3]
		wr_status && trig_en && pwdata[BIT_TSET] && !pwdata[BIT_TCLR]
			&& !(wr && paddr == ADDR_CONTROL) |=> running ##1 trig_state == TB_RUN)
		else $error("trigger set did not start timer");
	trig_clear_a: assert property ( // [R4]
		wr_status && trig_en && pwdata[BIT_TCLR] |=> !running ##1 tb == 32'h0)
		else $error("trigger clear did not hold timer");
	held_tb_zero_a: assert property ( // [R2]
		!running && !(wr && (paddr == ADDR_TB_LOW || paddr == ADDR_TB_HIGH))
			|=> tb == 32'h0)
		else $error("held timer not at zero");
	tb_wrap_a: assert property ( // [R11]
		running && tb == period && !(wr && (paddr == ADDR_TB_LOW || paddr == ADDR_TB_HIGH))
			|=> tb == 32'h0)
		else $error("time base did not wrap at period");
	compare_flag_a: assert property ( // [R17]
		running && tb[15:0] == cmp_pri |=> sce && irq_st[IRQ_COMPARE])
		else $error("compare match did not set flag");
	sce_sticky_a: assert property ( // [R7]
		sce && !(wr_status && !pwdata[BIT_SCE]) |=> sce)
		else $error("compare flag dropped without clear");
	cap_disable_a: assert property ( // [R8]
		cdis && !pop |=> count == $past(count))
		else $error("capture taken while disabled");
	overflow_set_a: assert property ( // [R9]
		push && full && !pop |=> cov && count == CAP_FULL)
		else $error("overflow not flagged");
	buffer_status_a: assert property ( // [R10]
		setup && !pwrite && paddr == ADDR_STATUS |=> prdata[BIT_CBNE] == ($past(count) != 3'h0))
		else $error("buffer status mismatch");
	gate_fall_a: assert property ( // [R15]
		gsm == GSM_FALL && armed && gate_fall |=> cdis && !armed)
		else $error("one-shot falling gate not applied");
	shutdown_hold_a: assert property ( // [R5]
		shutdown_request |=> asd && shutdown_active)
		else $error("shutdown status not set");
endmodule : ccpst_top

// ==== pkg/ccpst_pkg.sv ====
// Constants for the capture/compare status, time base and compare block
package ccpst_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_STATUS = 10'h330;
	localparam logic [9:0] IDX_TB_LOW = 10'h334;
	localparam logic [9:0] IDX_TB_HIGH = 10'h336;
	localparam logic [9:0] IDX_PER_LOW = 10'h338;
	localparam logic [9:0] IDX_PER_HIGH = 10'h33A;
	localparam logic [9:0] IDX_CMP_PRI = 10'h33C;
	localparam logic [9:0] IDX_CMP_SEC = 10'h340;
	localparam logic [9:0] IDX_CAPBUF_LOW = 10'h344;
	localparam logic [9:0] IDX_CAPBUF_HIGH = 10'h346;
	localparam logic [9:0] IDX_CONTROL = 10'h348;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h34A;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h34C;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [11:0] ADDR_TB_LOW = {IDX_TB_LOW, 2'h0};
	localparam logic [11:0] ADDR_TB_HIGH = {IDX_TB_HIGH, 2'h0};
	localparam logic [11:0] ADDR_PER_LOW = {IDX_PER_LOW, 2'h0};
	localparam logic [11:0] ADDR_PER_HIGH = {IDX_PER_HIGH, 2'h0};
	localparam logic [11:0] ADDR_CMP_PRI = {IDX_CMP_PRI, 2'h0};
	localparam logic [11:0] ADDR_CMP_SEC = {IDX_CMP_SEC, 2'h0};
	localparam logic [11:0] ADDR_CAPBUF_LOW = {IDX_CAPBUF_LOW, 2'h0};
	localparam logic [11:0] ADDR_CAPBUF_HIGH = {IDX_CAPBUF_HIGH, 2'h0};
	localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
	// Status register fields
	localparam int BIT_GATE_ARM = 10;
	localparam int BIT_TRIG = 7;
	localparam int BIT_TSET = 6;
	localparam int BIT_TCLR = 5;
	localparam int BIT_ASD = 4;
	localparam int BIT_SCE = 3;
	localparam int BIT_CDIS = 2;
	localparam int BIT_COV = 1;
	localparam int BIT_CBNE = 0;
	// Control register fields
	localparam int CTL_TRIGGERED_OPERATION_ENABLE = 0;
	localparam int CTL_GSM_LO = 1;
	localparam int CTL_GSM_HI = 2;
	// Interrupt status and mask fields
	localparam int IRQ_W = 4;
	localparam int IRQ_COMPARE = 0;
	localparam int IRQ_CAPTURE = 1;
	localparam int IRQ_OVERFLOW = 2;
	localparam int IRQ_SHUTDOWN = 3;
	// Capture FIFO
	localparam int CAP_PTR_W = 2;
	localparam logic [2:0] CAP_FULL = 3'h4;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	typedef enum logic [1:0] {
		GSM_LEVEL = 2'b00,
		GSM_RISE = 2'b01,
		GSM_FALL = 2'b10,
		GSM_RSVD = 2'b11
	} ccpst_gsm_e;
	typedef enum logic {
		TB_HELD = 1'b0,
		TB_RUN = 1'b1
	} ccpst_trig_e;
endpackage : ccpst_pkg
